/* rtl/trace_port_regs.svh */
`ifndef TRACE_PORT_REGS_SVH
`define TRACE_PORT_REGS_SVH

// Processor status nibbles
`define STAT_CONTINUE 4'h0
`define STAT_TAKEN 4'h5
`define STAT_FOLDED 4'h6
`define STAT_RET_EXC 4'h7
`define STAT_EXCEPTION 4'hc
`define STAT_EMULATION 4'hd
`define STAT_BKPT_STOP 4'he
`define STAT_HALTED 4'hf

// Size marker is 2'b10 followed by the byte count minus one
`define STAT_MARKER_HIGH 2'h2
`define SIZE_FOUR_BYTES 2'h3
`define SIZE_TWO_BYTES 2'h1
`define SIZE_ZERO 2'h0

// Left-justified trigger status after a single breakpoint code
`define TRIG_NONE 4'h0
`define TRIG_WAIT1 4'h2
`define TRIG_HIT1 4'h4
`define TRIG_WAIT2 4'ha
`define TRIG_HIT2 4'hc

`define NIB_ALL_ONES 4'hf
`define PORT_RESET 8'h00
`define FIFO_DEPTH 3'h4
`define LEFT_ONE 4'h1
`define LEFT_TWO 4'h2
`define LEFT_ZERO 4'h0

`endif

/* rtl/trace_pkg.sv */
package trace_pkg;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_DATA = 2'b01,
    GEN_TRIG = 2'b11
  } gen_mode_e;

  typedef enum logic [2:0] {
    BP_NONE = 3'h0,
    BP_WAIT1 = 3'h1,
    BP_HIT1 = 3'h2,
    BP_WAIT2 = 3'h3,
    BP_HIT2 = 3'h4
  } bp_level_e;

  typedef struct packed {
    logic [31:0] value;
    logic [1:0] size_m1;
  } fifo_entry_s;

  typedef struct packed {
    logic valid;
    logic [31:0] value;
    logic [1:0] size_m1;
  } capture_s;

  typedef struct packed {
    logic taken_branch;
    logic folded_branch;
    logic exc_return;
  } flow_event_s;

  typedef struct packed {
    logic exc_active;
    logic emu_active;
    logic stopped;
    logic halted;
  } core_mode_s;

  typedef struct packed {
    fifo_entry_s [3:0] mem;
    logic [1:0] rd;
    logic [1:0] wr;
    logic [2:0] count;
  } fifo_state_s;

  typedef struct packed {
    gen_mode_e mode;
    logic [31:0] word;
    logic [3:0] left;
    logic four_byte;
    logic no_halt;
    logic [3:0] trig_nib;
    logic chg_pend;
    logic [3:0] chg_nib;
    logic st_pend;
    logic [3:0] st_code;
    logic mark_sent;
    logic [7:0] port;
  } gen_state_s;

endpackage

/* rtl/trace_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trace_port_regs.svh"

module trace_fifo (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic push0_in,
  input var trace_pkg::fifo_entry_s push0_data_in,
  input wire logic push1_in,
  input var trace_pkg::fifo_entry_s push1_data_in,
  input wire logic pop_in,
  output trace_pkg::fifo_entry_s head_out,
  output logic has_out,
  output logic [2:0] free_out
);
  import trace_pkg::*;

  fifo_state_s r;
  fifo_state_s next_r;
  logic [1:0] wp;

  always_comb begin
    next_r = r;
    wp = r.wr;
    if (pop_in && r.count != 3'h0) begin
      next_r.rd = r.rd + 2'h1;
    end
    if (push0_in) begin
      next_r.mem[wp] = push0_data_in;
      wp = wp + 2'h1;
    end
    if (push1_in) begin
      next_r.mem[wp] = push1_data_in;
      wp = wp + 2'h1;
    end
    next_r.wr = wp;
    next_r.count = r.count + {2'h0, push0_in} + {2'h0, push1_in} - {2'h0, pop_in && r.count != 3'h0};
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign head_out = r.mem[r.rd];
  assign has_out = r.count != 3'h0;
  assign free_out = `FIFO_DEPTH - r.count;

endmodule
`default_nettype wire

/* rtl/trigger_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trace_port_regs.svh"

module trigger_encoder (
  input var trace_pkg::bp_level_e level_in,
  output logic [3:0] nib_out
);
  import trace_pkg::*;

  always_comb begin
    case (level_in)
      BP_NONE: nib_out = `TRIG_NONE;
      BP_WAIT1: nib_out = `TRIG_WAIT1;
      BP_HIT1: nib_out = `TRIG_HIT1;
      BP_WAIT2: nib_out = `TRIG_WAIT2;
      BP_HIT2: nib_out = `TRIG_HIT2;
      default: nib_out = `TRIG_NONE;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/realtime_trace_status_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trace_port_regs.svh"

// What this block does
// - Taken branch start shows status 0x5.
// - Folded taken conditional branch with target start shows 0x6.
// - Return-from-exception start shows 0x7.
// - Every data display opens with marker 0x8..0xB giving byte count.
// - Marker leads its first data nibble by exactly one clock.
// - Ordinary exception processing holds 0xC every cycle until done.
// - Emulation-mode exception holds 0xD instead until done.
// - Breakpoint state change: one 0xE then the trigger status nibble.
// - Trigger nibble codes 0x0, 0x2, 0x4, 0xA, 0xC by level.
// - Stopped processor shows 0xE continuously; two 0xE mean stopped.
// - Halted processor drives 0xF on both nibbles every cycle.
// - Target address bytes and nibbles go out least significant first.
// - Only variant-addressed taken branches and vectors capture targets.
// - Target display optional, 2, 3 or 4 bytes, marker 0x9..0xB.
// - Two-byte target: byte 0x59 then four address nibbles.
// - Data always follows a marker, so at most four 0xFF data bytes.
// - No halted code right after four-byte display ending in all ones.
// - Codes and data may sit on either nibble of the port; markers only on the low one.
// - Marker and data go contiguously; idle 0x0 elsewhere.
// - Captures queue in a four-entry 32-bit buffer, two nibbles a cycle.
// - Dual capture with too few free entries stalls the core.
module realtime_trace_status_port (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic STATUS_VALID_IN,
  input var trace_pkg::flow_event_s FLOW_IN,
  input var trace_pkg::core_mode_s MODE_IN,
  input wire logic TGT_DISPLAY_EN_IN,
  input wire logic [1:0] TGT_BYTES_IN,
  input wire logic TGT_VALID_IN,
  input wire logic [31:0] TGT_ADDR_IN,
  input var trace_pkg::capture_s CAP_A_IN,
  input var trace_pkg::capture_s CAP_B_IN,
  input wire logic BKPT_CHANGE_IN,
  input var trace_pkg::bp_level_e BKPT_LEVEL_IN,
  output logic CORE_STALL_OUT,
  output logic [7:0] TRACE_OUTPUT_PORT_OUT
);
  import trace_pkg::*;

  gen_state_s r;
  gen_state_s next_r;
  gen_state_s mid;
  fifo_entry_s head;
  fifo_entry_s push0_data;
  fifo_entry_s push1_data;
  logic fifo_has;
  logic [2:0] fifo_free;
  logic pop;
  logic pop_unused;
  logic push0;
  logic push1;
  logic tgt_push;
  logic [1:0] need;
  logic [1:0] tgt_size;
  logic [3:0] nib_hi;
  logic [3:0] nib_lo;
  logic [3:0] trig_now;
  logic [3:0] status_code;
  logic accept;

  // Emits one nibble: data runs to its end, then the posting in order of priority
  function automatic gen_state_s step(input gen_state_s s, input core_mode_s m, input logic slot1,
                                      input logic has, input fifo_entry_s hd,
                                      output logic [3:0] nib, output logic popped);
    gen_state_s n;
    n = s;
    nib = `STAT_CONTINUE;
    popped = 1'b0;
    if (s.mode == GEN_DATA) begin
      nib = s.word[3:0];
      n.word = {4'h0, s.word[31:4]};
      n.left = s.left - `LEFT_ONE;
      n.no_halt = 1'b0;
      if (s.left == `LEFT_ONE) begin
        n.mode = GEN_IDLE;
        n.no_halt = s.four_byte && (s.word[3:0] == `NIB_ALL_ONES);
      end
    end else if (s.mode == GEN_TRIG) begin
      nib = s.trig_nib;
      n.mode = GEN_IDLE;
      n.no_halt = 1'b0;
    end else if (m.halted) begin
      nib = s.no_halt ? `STAT_CONTINUE : `STAT_HALTED;
      n.no_halt = 1'b0;
    end else begin
      n.no_halt = 1'b0;
      if (s.st_pend) begin
        nib = s.st_code;
        n.st_pend = 1'b0;
      end else if (m.emu_active) begin
        nib = `STAT_EMULATION;
      end else if (m.exc_active) begin
        nib = `STAT_EXCEPTION;
      end else if (s.chg_pend) begin
        nib = `STAT_BKPT_STOP;
        n.chg_pend = 1'b0;
        n.trig_nib = s.chg_nib;
        n.mode = GEN_TRIG;
      end else if (m.stopped) begin
        nib = `STAT_BKPT_STOP;
      end else if (has && slot1) begin
        // Marker only in the second nibble, so its data starts on the next clock
        nib = {`STAT_MARKER_HIGH, hd.size_m1};
        n.word = hd.value;
        n.left = 4'(({2'h0, hd.size_m1} + `LEFT_ONE) << 1);
        n.four_byte = hd.size_m1 == `SIZE_FOUR_BYTES;
        n.mode = GEN_DATA;
        popped = 1'b1;
      end
    end
    return n;
  endfunction

  trigger_encoder u_trig (
    .level_in(BKPT_LEVEL_IN),
    .nib_out(trig_now)
  );

  trace_fifo u_fifo (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .push0_in(push0),
    .push0_data_in(push0_data),
    .push1_in(push1),
    .push1_data_in(push1_data),
    .pop_in(pop),
    .head_out(head),
    .has_out(fifo_has),
    .free_out(fifo_free)
  );

  always_comb begin
    tgt_size = (TGT_BYTES_IN == `SIZE_ZERO) ? `SIZE_TWO_BYTES : TGT_BYTES_IN;
    tgt_push = TGT_VALID_IN && TGT_DISPLAY_EN_IN;
    need = {1'b0, tgt_push} + {1'b0, CAP_A_IN.valid} + {1'b0, CAP_B_IN.valid};
    CORE_STALL_OUT = ({1'b0, need} > fifo_free) || (STATUS_VALID_IN && r.st_pend);
    accept = !CORE_STALL_OUT;
    // First two valid captures, target first
    push0_data = tgt_push ? {TGT_ADDR_IN, tgt_size} :
                 CAP_A_IN.valid ? {CAP_A_IN.value, CAP_A_IN.size_m1} : {CAP_B_IN.value, CAP_B_IN.size_m1};
    push1_data = (tgt_push && CAP_A_IN.valid) ? {CAP_A_IN.value, CAP_A_IN.size_m1} :
                 {CAP_B_IN.value, CAP_B_IN.size_m1};
    push0 = accept && (need != 2'h0);
    push1 = accept && (need[1]);
    if (FLOW_IN.folded_branch) begin
      status_code = `STAT_FOLDED;
    end else if (FLOW_IN.exc_return) begin
      status_code = `STAT_RET_EXC;
    end else begin
      status_code = `STAT_TAKEN;
    end
  end

  always_comb begin
    mid = step(r, MODE_IN, 1'b0, fifo_has, head, nib_hi, pop_unused);
    next_r = step(mid, MODE_IN, 1'b1, fifo_has, head, nib_lo, pop);
    next_r.port = {nib_hi, nib_lo};
    next_r.mark_sent = pop;
    if (STATUS_VALID_IN && accept) begin
      next_r.st_pend = 1'b1;
      next_r.st_code = status_code;
    end
    // A new change wins over the posting that consumes the old one
    if (BKPT_CHANGE_IN) begin
      next_r.chg_pend = 1'b1;
      next_r.chg_nib = trig_now;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign TRACE_OUTPUT_PORT_OUT = r.port;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  sequence bkpt_code_s;
    r.mode == GEN_TRIG && r.port[3:0] == `STAT_BKPT_STOP;
  endsequence

  sequence trig_follow_s;
    TRACE_OUTPUT_PORT_OUT[7:4] == $past(r.trig_nib);
  endsequence

  taken_status_a: assert property (
    STATUS_VALID_IN && accept && FLOW_IN.taken_branch && !FLOW_IN.folded_branch && !FLOW_IN.exc_return
    |=> r.st_pend && r.st_code == `STAT_TAKEN)
    else $error("taken branch status not queued as 0x5");

  marker_count_a: assert property (
    r.mark_sent |-> r.mode == GEN_DATA && r.left == 4'(({2'h0, r.port[1:0]} + `LEFT_ONE) << 1)
                    && r.port[3:2] == `STAT_MARKER_HIGH)
    else $error("marker not followed by its data count");

  data_order_a: assert property (
    r.mode == GEN_DATA && r.left > `LEFT_ONE |=> r.port[7:4] == $past(r.word[3:0])
                                               && r.port[3:0] == $past(r.word[7:4]))
    else $error("data nibbles out of order");

  exc_code_a: assert property (
    MODE_IN.exc_active && !MODE_IN.emu_active && !MODE_IN.halted && r.mode == GEN_IDLE && !r.st_pend
    |=> TRACE_OUTPUT_PORT_OUT == {`STAT_EXCEPTION, `STAT_EXCEPTION})
    else $error("exception code not held");

  emu_code_a: assert property (
    MODE_IN.emu_active && !MODE_IN.halted && r.mode == GEN_IDLE && !r.st_pend
    |=> TRACE_OUTPUT_PORT_OUT == {`STAT_EMULATION, `STAT_EMULATION})
    else $error("emulation code not held");

  bkpt_pair_a: assert property (bkpt_code_s |=> trig_follow_s)
    else $error("trigger status missing after breakpoint code");

  trig_encode_a: assert property (
    BKPT_CHANGE_IN && BKPT_LEVEL_IN == BP_WAIT2 |=> r.chg_pend && r.chg_nib == `TRIG_WAIT2)
    else $error("trigger level encoded wrongly");

  stop_code_a: assert property (
    MODE_IN.stopped && !MODE_IN.halted && !MODE_IN.exc_active && !MODE_IN.emu_active
    && r.mode == GEN_IDLE && !r.st_pend && !r.chg_pend
    |=> TRACE_OUTPUT_PORT_OUT == {`STAT_BKPT_STOP, `STAT_BKPT_STOP})
    else $error("stopped code not shown");

  halt_both_a: assert property (
    MODE_IN.halted && r.mode == GEN_IDLE && !r.no_halt
    |=> TRACE_OUTPUT_PORT_OUT == {`STAT_HALTED, `STAT_HALTED})
    else $error("halted code not on both nibbles");

  no_halt_a: assert property (
    r.no_halt |=> TRACE_OUTPUT_PORT_OUT[7:4] != `STAT_HALTED)
    else $error("halted code directly after all-ones data");

  dual_stall_a: assert property (
    CAP_A_IN.valid && CAP_B_IN.valid && fifo_free < 3'h2 |-> CORE_STALL_OUT && !push0 && !push1)
    else $error("dual capture not stalled");

  idle_zero_a: assert property (
    $rose(r.mode == GEN_IDLE) ##0 !r.st_pend && !r.chg_pend && !fifo_has && MODE_IN == '0
    && !STATUS_VALID_IN && !BKPT_CHANGE_IN && !r.no_halt |=> TRACE_OUTPUT_PORT_OUT == `PORT_RESET)
    else $error("idle code not driven");

  sequence status_ready_s;
    r.st_pend && r.mode == GEN_IDLE && !MODE_IN.halted;
  endsequence

  sequence data_more_s;
    r.mode == GEN_DATA && r.left > `LEFT_TWO;
  endsequence

  folded_status_a: assert property (
    STATUS_VALID_IN && accept && FLOW_IN.folded_branch |=> r.st_pend && r.st_code == `STAT_FOLDED)
    else $error("folded branch status not queued as 0x6");

  return_status_a: assert property (
    STATUS_VALID_IN && accept && FLOW_IN.exc_return && !FLOW_IN.folded_branch
    |=> r.st_pend && r.st_code == `STAT_RET_EXC)
    else $error("return status not queued as 0x7");

  status_post_a: assert property (
    status_ready_s |=> TRACE_OUTPUT_PORT_OUT[7:4] == $past(r.st_code))
    else $error("pending status not posted in first nibble");

  bkpt_post_a: assert property (
    r.chg_pend && r.mode == GEN_IDLE && !r.st_pend
    && !MODE_IN.halted && !MODE_IN.emu_active && !MODE_IN.exc_active
    |=> TRACE_OUTPUT_PORT_OUT == {`STAT_BKPT_STOP, $past(r.chg_nib)})
    else $error("breakpoint code and trigger status not paired");

  marker_lead_a: assert property (
    r.mark_sent |=> TRACE_OUTPUT_PORT_OUT[7:4] == $past(r.word[3:0]))
    else $error("first data nibble not one clock after marker");

  data_run_a: assert property (
    data_more_s |=> r.mode == GEN_DATA && r.left == $past(r.left) - `LEFT_TWO)
    else $error("data display interrupted");

  data_end_a: assert property (
    r.mode == GEN_DATA && r.left == `LEFT_TWO |=> r.mode == GEN_IDLE)
    else $error("data display ran past its count");

  tgt_gate_a: assert property (
    !TGT_DISPLAY_EN_IN && !CAP_A_IN.valid && !CAP_B_IN.valid |-> !push0 && !push1)
    else $error("target queued while display disabled");

  reset_idle_a: assert property (@(posedge CLK_IN) disable iff (1'b0)
    SYS_RST_IN |=> TRACE_OUTPUT_PORT_OUT == `PORT_RESET && r.mode == GEN_IDLE)
    else $error("port not idle after reset");

endmodule
`default_nettype wire

/* dv/trace_observer.sv */
`timescale 1ns/1ps
`default_nettype none
module trace_observer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] port_in,
  output logic halted_out
);
  logic [3:0] nib_run;
  logic [2:0] byte_run;
  logic [3:0] r;
  // Nine 0xF nibbles or five 0xFF bytes in a row mean the core is halted
  assign halted_out = (nib_run >= 4'h9) || (byte_run >= 3'h5);
  always @(posedge clk_in) begin
    if (rst_in) begin
      nib_run <= 4'h0;
      byte_run <= 3'h0;
    end else begin
      r = nib_run;
      r = (port_in[7:4] == 4'hf) ? r + {3'h0, r < 4'h9} : 4'h0;
      r = (port_in[3:0] == 4'hf) ? r + {3'h0, r < 4'h9} : 4'h0;
      nib_run <= r;
      byte_run <= (port_in == 8'hff) ? byte_run + {2'h0, byte_run < 3'h5} : 3'h0;
    end
  end
endmodule
`default_nettype wire

/* dv/test_realtime_trace_status_port.sv */
`timescale 1ns/1ps
`default_nettype none
module test_realtime_trace_status_port;
  import trace_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic st_valid = 1'b0;
  flow_event_s flow = '0;
  core_mode_s mode = '0;
  logic tgt_en = 1'b0;
  logic [1:0] tgt_bytes = 2'h1;
  logic tgt_valid = 1'b0;
  logic [31:0] tgt_addr = 32'h0;
  capture_s cap_a = '0;
  capture_s cap_b = '0;
  logic bk_chg = 1'b0;
  bp_level_e bk_lvl = BP_NONE;
  logic stall;
  logic [7:0] port;
  logic halted_seen;
  logic collect = 1'b0;
  logic [3:0] nibs[$];
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  realtime_trace_status_port realtime_trace_status_port_i (
    .CLK_IN(clk),
    .SYS_RST_IN(rst),
    .STATUS_VALID_IN(st_valid),
    .FLOW_IN(flow),
    .MODE_IN(mode),
    .TGT_DISPLAY_EN_IN(tgt_en),
    .TGT_BYTES_IN(tgt_bytes),
    .TGT_VALID_IN(tgt_valid),
    .TGT_ADDR_IN(tgt_addr),
    .CAP_A_IN(cap_a),
    .CAP_B_IN(cap_b),
    .BKPT_CHANGE_IN(bk_chg),
    .BKPT_LEVEL_IN(bk_lvl),
    .CORE_STALL_OUT(stall),
    .TRACE_OUTPUT_PORT_OUT(port)
  );

  trace_observer trace_observer_i (
    .clk_in(clk),
    .rst_in(rst),
    .port_in(port),
    .halted_out(halted_seen)
  );

  // Port only moves on rising edges, so the falling edge sees it settled
  always @(negedge clk) begin
    if (collect) begin
      nibs.push_back(port[7:4]);
      nibs.push_back(port[3:0]);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_flow();
    flow_event_s f[3] = '{3'b100, 3'b010, 3'b001};
    logic [3:0] c[3] = '{4'h5, 4'h6, 4'h7};
    for (int i = 0; i < 3; i++) begin
      flow = f[i];
      st_valid = 1'b1;
      tick(1);
      st_valid = 1'b0;
      tick(1);
      check(port, {c[i], 4'h0});
    end
  endtask

  task automatic t_target();
    tgt_en = 1'b1;
    tgt_addr = 32'h1234_abcd;
    flow = 3'b100;
    st_valid = 1'b1;
    tgt_valid = 1'b1;
    tick(1);
    st_valid = 1'b0;
    tgt_valid = 1'b0;
    tick(1);
    check(port, 8'h59);
    tick(1);
    check(port, 8'hdc);
    tick(1);
    check(port, 8'hba);
    tick(1);
    check(port, 8'h00);
    tgt_bytes = 2'h3;
    tgt_addr = 32'hffff_ffff;
    st_valid = 1'b1;
    tgt_valid = 1'b1;
    tick(1);
    st_valid = 1'b0;
    tgt_valid = 1'b0;
    tick(1);
    check(port, 8'h5b);
    mode.halted = 1'b1;
    repeat (4) begin
      tick(1);
      check(port, 8'hff);
    end
    tick(1);
    check(port[7:4], 4'h0);
    check(halted_seen, 1'b0);
    tick(6);
    check(port, 8'hff);
    check(halted_seen, 1'b1);
    mode.halted = 1'b0;
    tgt_en = 1'b0;
    tgt_bytes = 2'h1;
    tick(3);
    check(port, 8'h00);
  endtask

  task automatic t_modes();
    core_mode_s m[3] = '{4'b1000, 4'b1100, 4'b0010};
    logic [7:0] e[3] = '{8'hcc, 8'hdd, 8'hee};
    for (int i = 0; i < 3; i++) begin
      mode = m[i];
      tick(2);
      repeat (3) begin
        check(port, e[i]);
        tick(1);
      end
      mode = '0;
      tick(2);
      check(port, 8'h00);
    end
  endtask

  task automatic t_bkpt();
    bp_level_e l[5] = '{BP_NONE, BP_WAIT1, BP_HIT1, BP_WAIT2, BP_HIT2};
    logic [3:0] t[5] = '{4'h0, 4'h2, 4'h4, 4'ha, 4'hc};
    int k;
    for (int i = 0; i < 5; i++) begin
      nibs = {};
      collect = 1'b1;
      bk_lvl = l[i];
      bk_chg = 1'b1;
      tick(1);
      bk_chg = 1'b0;
      tick(4);
      collect = 1'b0;
      k = -1;
      for (int j = 0; j + 1 < nibs.size(); j++) begin
        if (nibs[j] == 4'he && k < 0) begin
          k = j;
        end
      end
      check((k >= 0) ? nibs[k + 1] : 4'hx, t[i]);
    end
  endtask

  task automatic t_fifo();
    logic [3:0] q[$];
    logic [3:0] e[$];
    bit hit = 0;
    int w = 0;
    nibs = {};
    collect = 1'b1;
    for (int i = 1; i <= 6; i += 2) begin
      cap_a = {1'b1, 24'h765432, 4'h1, 4'(i), 2'h3};
      cap_b = {1'b1, 24'h765432, 4'h1, 4'(i + 1), 2'h3};
      e = {e, 4'hb, 4'(i), 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
      e = {e, 4'hb, 4'(i + 1), 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
      #1;
      while (stall === 1'b1 && w < 60) begin
        hit = 1;
        w++;
        tick(1);
        #1;
      end
      tick(1);
    end
    cap_a = '0;
    cap_b = '0;
    tick(45);
    collect = 1'b0;
    check(hit, 1'b1);
    check(stall, 1'b0);
    foreach (nibs[j]) begin
      if (nibs[j] != 4'h0) begin
        q.push_back(nibs[j]);
      end
    end
    check(q.size(), 54);
    foreach (e[j]) begin
      check((j < q.size()) ? q[j] : 4'hx, e[j]);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(8);
    rst = 1'b0;
    tick(1);
    check(port, 8'h00);
    check(stall, 1'b0);
    t_flow();
    t_target();
    t_modes();
    t_bkpt();
    t_fifo();
    report_and_stop();
  end
endmodule
`default_nettype wire
